// [pkg/alc_pkg.sv]
// Constants for the averaging limit comparator
// Assumes a 50 MHz clock and APB word-aligned registers
package alc_pkg;
    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_HYST = 8'h04;
    localparam logic [7:0] OFS_SP1H = 8'h08;
    localparam logic [7:0] OFS_SP1L = 8'h0c;
    localparam logic [7:0] OFS_SP2H = 8'h10;
    localparam logic [7:0] OFS_SP2L = 8'h14;
    localparam logic [7:0] OFS_ACT  = 8'h18;
    localparam logic [7:0] OFS_AVG  = 8'h1c;
    localparam logic [7:0] OFS_STAT = 8'h20;
    localparam logic [7:0] OFS_IST  = 8'h24;
    localparam logic [7:0] OFS_IEN  = 8'h28;
    localparam logic [7:0] OFS_ICLR = 8'h2c;
    // ----------------------------------------
    // Control fields and reset values
    // ----------------------------------------
    localparam int CTRL_W        = 6;
    localparam int CTRL_SEL_LSB  = 0;
    localparam int CTRL_COL_LSB  = 2;
    localparam int CTRL_TMR_BIT  = 4;
    localparam int CTRL_SLOW_BIT = 5;
    localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
    // ----------------------------------------
    // Actions, colours, error codes, events
    // ----------------------------------------
    localparam logic [1:0] ACT_UP    = 2'h0;
    localparam logic [1:0] ACT_LO    = 2'h1;
    localparam logic [1:0] ACT_RNG   = 2'h2;
    localparam logic [1:0] COL_G2R   = 2'h0;
    localparam logic [1:0] COL_GRN   = 2'h1;
    localparam logic [1:0] COL_RED   = 2'h2;
    localparam logic [1:0] COL_R2G   = 2'h3;
    localparam logic [1:0] ERR_NONE  = 2'h0;
    localparam logic [1:0] ERR_RAM   = 2'h1;
    localparam logic [1:0] ERR_NVM   = 2'h2;
    localparam int EV_UPD = 0;
    localparam int EV_O1  = 1;
    localparam int EV_O2  = 2;
    localparam int EV_RAM = 3;
    localparam int EV_NVM = 4;
    localparam int EV_W   = 5;
    // ----------------------------------------
    // Timing and widths
    // ----------------------------------------
    localparam int unsigned CLK_HZ       = 50_000_000;
    localparam int unsigned BASE_FAST_MS = 250;
    localparam int unsigned BASE_SLOW_MS = 500;
    localparam int unsigned FAST_CYC = BASE_FAST_MS * (CLK_HZ / 1000);
    localparam int unsigned SLOW_CYC = BASE_SLOW_MS * (CLK_HZ / 1000);
    localparam int TCNT_W   = 25;
    localparam int PV_W_DEF = 20;
endpackage : alc_pkg

// [pkg/alc_cmp_if.sv]
// Link from the averaging core to one limit comparator
// Assumes both ends run on the same clock
`timescale 1ns/1ns
interface alc_cmp_if #(parameter int W = 20);
    logic signed [W-1:0] pv;
    logic                upd;
    logic signed [W-1:0] sp_hi;
    logic signed [W-1:0] sp_lo;
    logic signed [W-1:0] hyst;
    logic [1:0]          act;
    logic                out;
    modport ctl (output pv, upd, sp_hi, sp_lo, hyst, act, input out);
    modport cmp (input pv, upd, sp_hi, sp_lo, hyst, act, output out);
endinterface : alc_cmp_if

// [src/alc_cmp.sv]
// One comparative output with hysteresis
// Assumes settings stay stable while upd pulses
`timescale 1ns/1ns
module alc_cmp #(
    parameter int W = alc_pkg::PV_W_DEF
) (
    input  wire logic clk_i,
    input  wire logic resetn_i,
    alc_cmp_if.cmp    c
);
    import alc_pkg::*;

    typedef struct packed {
        logic out;
    } alc_cmp_st_t;

    alc_cmp_st_t         s_q;
    alc_cmp_st_t         s_d;
    logic signed [W:0]   pv;
    logic signed [W:0]   hi;
    logic signed [W:0]   lo;
    logic signed [W:0]   h;
    logic                up_on;
    logic                up_off;
    logic                lo_on;
    logic                lo_off;

    // Widened compare terms, no overflow
    assign pv     = (W+1)'(c.pv);
    assign hi     = (W+1)'(c.sp_hi);
    assign lo     = (W+1)'(c.sp_lo);
    assign h      = (W+1)'(c.hyst);
    assign up_on  = pv >= hi;
    assign up_off = pv <= hi - h;
    assign lo_on  = pv <= lo;
    assign lo_off = pv >= lo + h;

    // Next output, held between thresholds
    always_comb begin
        s_d = s_q;
        if (c.upd) begin
            case (c.act)
                ACT_UP: begin
                    if (up_on) s_d.out = 1'b1;
                    else if (up_off) s_d.out = 1'b0;
                end
                ACT_LO: begin
                    if (lo_on) s_d.out = 1'b1;
                    else if (lo_off) s_d.out = 1'b0;
                end
                ACT_RNG: begin
                    if (up_on || lo_on) s_d.out = 1'b1;
                    else if (up_off && lo_off) s_d.out = 1'b0;
                end
                default: s_d = s_q;
            endcase
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (!resetn_i) s_q <= '0;
        else s_q <= s_d;
    end

    assign c.out = s_q.out;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    AST_UP_ON: assert property (
        c.upd && c.act == ACT_UP && c.pv >= c.sp_hi |=> c.out)
        else $error("upper action did not turn on");
    AST_UP_OFF: assert property (
        c.upd && c.act == ACT_UP && !up_on && up_off |=> !c.out)
        else $error("upper action did not turn off");
    AST_LO_ON: assert property (
        c.upd && c.act == ACT_LO && c.pv <= c.sp_lo |=> c.out)
        else $error("lower action did not turn on");
    AST_RNG_ON: assert property (
        c.upd && c.act == ACT_RNG && (up_on || lo_on) |=> c.out)
        else $error("range action did not turn on");
    AST_RNG_OFF: assert property (
        c.upd && c.act == ACT_RNG && !up_on && !lo_on
        && up_off && lo_off |=> !c.out)
        else $error("range action did not turn off");
    AST_HOLD: assert property (
        !c.upd |=> $stable(c.out))
        else $error("output moved without an update");
endmodule : alc_cmp

// [src/alc_top.sv]
// Averaging and limit comparator stage with APB registers
// Assumes pv_i and fault inputs come from logic on clk_i
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/1ns
module alc_top #(
    parameter int          PV_W     = alc_pkg::PV_W_DEF,
    parameter int unsigned FAST_CYC = alc_pkg::FAST_CYC,
    parameter int unsigned SLOW_CYC = alc_pkg::SLOW_CYC
) (
    input  wire logic                   clk_i,
    input  wire logic                   resetn_i,
    input  wire logic                   psel_i,
    input  wire logic                   penable_i,
    input  wire logic                   pwrite_i,
    input  wire logic [7:0]             paddr_i,
    input  wire logic [31:0]            pwdata_i,
    output logic [31:0]                 prdata_o,
    output logic                        pready_o,
    output logic                        pslverr_o,
    input  wire logic signed [PV_W-1:0] pv_i,
    input  wire logic                   pv_valid_i,
    input  wire logic                   ram_fault_i,
    input  wire logic                   nvm_fault_i,
    output logic signed [PV_W-1:0]      avg_o,
    output logic                        avg_vld_o,
    output logic                        cmp1_o,
    output logic                        cmp2_o,
    output logic                        disp_green_o,
    output logic                        disp_red_o,
    output logic [1:0]                  err_code_o,
    output logic                        lvl_dark_o,
    output logic                        irq_o
);
    import alc_pkg::*;

    localparam int SW = PV_W + 3;

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [CTRL_W-1:0]      ctrl;
        logic [3:0]             act;
        logic signed [PV_W-1:0] hyst;
        logic signed [PV_W-1:0] sp1h;
        logic signed [PV_W-1:0] sp1l;
        logic signed [PV_W-1:0] sp2h;
        logic signed [PV_W-1:0] sp2l;
        logic signed [PV_W-1:0] pv_last;
        logic signed [PV_W-1:0] avg;
        logic [TCNT_W-1:0]      tcnt;
        logic signed [SW-1:0]   sum;
        logic [2:0]             cnt;
        logic                   upd;
        logic [1:0]             o_prev;
        logic [EV_W-1:0]        ist;
        logic [EV_W-1:0]        ien;
        logic                   ram_err;
        logic                   nvm_err;
        logic [1:0]             err;
        logic                   green;
        logic                   red;
        logic [31:0]            rdata;
    } alc_top_st_t;

    alc_top_st_t            s_q;
    alc_top_st_t            s_d;
    logic                   setup;
    logic                   wr;
    logic                   hit;
    logic                   wr_ctrl;
    logic                   sel_chg;
    logic                   tmr;
    logic [1:0]             sel;
    logic [1:0]             col;
    logic [TCNT_W-1:0]      per;
    logic                   tick;
    logic                   smp_ev;
    logic signed [PV_W-1:0] smp;
    logic signed [SW-1:0]   sum_n;
    logic [3:0]             nlen;
    logic                   any_on;
    logic [EV_W-1:0]        ev;
    logic [EV_W-1:0]        clr;
    logic [31:0]            rmux;

    alc_cmp_if #(.W(PV_W)) c1 ();
    alc_cmp_if #(.W(PV_W)) c2 ();

    // Sign extension for read-back
    function automatic logic [31:0] sx(input logic signed [PV_W-1:0] v);
        return 32'(v);
    endfunction : sx

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    assign setup   = psel_i && !penable_i;
    assign wr      = psel_i && penable_i && pwrite_i;
    assign wr_ctrl = wr && paddr_i == OFS_CTRL;

    // Read mux and address hit
    always_comb begin
        hit  = 1'b1;
        rmux = 32'h0;
        case (paddr_i)
            OFS_CTRL: rmux = 32'(s_q.ctrl);
            OFS_HYST: rmux = sx(s_q.hyst);
            OFS_SP1H: rmux = sx(s_q.sp1h);
            OFS_SP1L: rmux = sx(s_q.sp1l);
            OFS_SP2H: rmux = sx(s_q.sp2h);
            OFS_SP2L: rmux = sx(s_q.sp2l);
            OFS_ACT:  rmux = 32'(s_q.act);
            OFS_AVG:  rmux = sx(s_q.avg);
            OFS_STAT: rmux = {28'h0, s_q.nvm_err, s_q.ram_err, c2.out, c1.out};
            OFS_IST:  rmux = 32'(s_q.ist);
            OFS_IEN:  rmux = 32'(s_q.ien);
            OFS_ICLR: rmux = 32'h0;
            default:  hit  = 1'b0;
        endcase
    end

    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i && penable_i && !hit;

    // ----------------------------------------
    // Update source and averaging terms
    // ----------------------------------------
    assign sel     = s_q.ctrl[CTRL_SEL_LSB +: 2];
    assign col     = s_q.ctrl[CTRL_COL_LSB +: 2];
    assign tmr     = s_q.ctrl[CTRL_TMR_BIT];
    assign sel_chg = wr_ctrl && pwdata_i[CTRL_SEL_LSB +: 2] != sel;

    // Base interval, 250 ms or 500 ms
    assign per  = s_q.ctrl[CTRL_SLOW_BIT] ? TCNT_W'(SLOW_CYC - 1)
                                          : TCNT_W'(FAST_CYC - 1);
    assign tick = tmr && s_q.tcnt == per;

    // One process-value update per tick or per pulse
    assign smp_ev = tmr ? tick : pv_valid_i;
    assign smp    = tmr ? s_q.pv_last : pv_i;
    assign sum_n  = s_q.sum + SW'(smp);
    assign nlen   = 4'h1 << sel;

    assign any_on = c1.out || c2.out;

    // Interrupt events and clear
    assign ev[EV_UPD] = s_q.upd;
    assign ev[EV_O1]  = c1.out && !s_q.o_prev[0];
    assign ev[EV_O2]  = c2.out && !s_q.o_prev[1];
    assign ev[EV_RAM] = ram_fault_i && !s_q.ram_err;
    assign ev[EV_NVM] = nvm_fault_i && !s_q.nvm_err;
    assign clr = (wr && paddr_i == OFS_ICLR) ? pwdata_i[EV_W-1:0] : '0;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        s_d     = s_q;
        s_d.upd = 1'b0;

        // Latest front-end value for timer mode
        if (pv_valid_i) s_d.pv_last = pv_i;

        // Base interval counter
        if (!tmr || tick) s_d.tcnt = '0;
        else s_d.tcnt = s_q.tcnt + 1'b1;

        // Accumulate N updates, then publish the mean
        if (sel_chg) begin
            s_d.sum = '0;
            s_d.cnt = 3'h0;
        end else if (smp_ev) begin
            if (4'(s_q.cnt) + 4'h1 == nlen) begin
                s_d.avg = PV_W'(sum_n >>> sel);
                s_d.upd = 1'b1;
                s_d.sum = '0;
                s_d.cnt = 3'h0;
            end else begin
                s_d.sum = sum_n;
                s_d.cnt = s_q.cnt + 3'h1;
            end
        end

        // Register writes
        if (wr) begin
            case (paddr_i)
                OFS_CTRL: s_d.ctrl = pwdata_i[CTRL_W-1:0];
                OFS_HYST: s_d.hyst = pwdata_i[PV_W-1:0];
                OFS_SP1H: s_d.sp1h = pwdata_i[PV_W-1:0];
                OFS_SP1L: s_d.sp1l = pwdata_i[PV_W-1:0];
                OFS_SP2H: s_d.sp2h = pwdata_i[PV_W-1:0];
                OFS_SP2L: s_d.sp2l = pwdata_i[PV_W-1:0];
                OFS_ACT:  s_d.act  = pwdata_i[3:0];
                OFS_IEN:  s_d.ien  = pwdata_i[EV_W-1:0];
                default:  s_d.act  = s_d.act;
            endcase
        end

        // Read data captured in the setup phase
        if (setup) s_d.rdata = rmux;

        // Sticky status, set wins over clear
        s_d.ist    = (s_q.ist & ~clr) | ev;
        s_d.o_prev = {c2.out, c1.out};

        // Storage faults latch until reset
        s_d.ram_err = s_q.ram_err || ram_fault_i;
        s_d.nvm_err = s_q.nvm_err || nvm_fault_i;
        s_d.err     = s_d.ram_err ? ERR_RAM :
                      s_d.nvm_err ? ERR_NVM : ERR_NONE;

        // Display colour from col, following the output states in two of its four modes
        case (col)
            COL_G2R: begin
                s_d.green = !any_on;
                s_d.red   = any_on;
            end
            COL_GRN: begin
                s_d.green = 1'b1;
                s_d.red   = 1'b0;
            end
            COL_RED: begin
                s_d.green = 1'b0;
                s_d.red   = 1'b1;
            end
            COL_R2G: begin
                s_d.green = any_on;
                s_d.red   = !any_on;
            end
            default: begin
                s_d.green = 1'b1;
                s_d.red   = 1'b0;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            s_q      <= '0;
            s_q.ctrl <= CTRL_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------
    // Comparators
    // ----------------------------------------
    assign c1.pv    = s_q.avg;
    assign c1.upd   = s_q.upd;
    assign c1.sp_hi = s_q.sp1h;
    assign c1.sp_lo = s_q.sp1l;
    assign c1.hyst  = s_q.hyst;
    assign c1.act   = s_q.act[1:0];
    assign c2.pv    = s_q.avg;
    assign c2.upd   = s_q.upd;
    assign c2.sp_hi = s_q.sp2h;
    assign c2.sp_lo = s_q.sp2l;
    assign c2.hyst  = s_q.hyst;
    assign c2.act   = s_q.act[3:2];

    alc_cmp #(.W(PV_W)) u_cmp1 (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .c        (c1.cmp)
    );

    alc_cmp #(.W(PV_W)) u_cmp2 (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .c        (c2.cmp)
    );

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign prdata_o     = s_q.rdata;
    assign avg_o        = s_q.avg;
    assign avg_vld_o    = s_q.upd;
    assign cmp1_o       = c1.out;
    assign cmp2_o       = c2.out;
    assign disp_green_o = s_q.green;
    assign disp_red_o   = s_q.red;
    assign err_code_o   = s_q.err;
    assign lvl_dark_o   = s_q.ram_err;
    assign irq_o        = |(s_q.ist & s_q.ien);

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    AST_AVG_ONE: assert property (
        smp_ev && !sel_chg && sel == 2'h0 |=> avg_vld_o && avg_o == $past(smp))
        else $error("single update not passed through");
    AST_UPD_SRC: assert property (
        avg_vld_o |-> $past(smp_ev) && !$past(sel_chg))
        else $error("mean published without an update");
    AST_TMR: assert property (
        tmr && !tick |=> !avg_vld_o)
        else $error("timer mode updated off the base tick");
    AST_PLS: assert property (
        !tmr && !pv_valid_i |=> !avg_vld_o)
        else $error("pulse mode updated without a pulse");
    AST_CLR: assert property (
        sel_chg |=> s_q.cnt == 3'h0 && s_q.sum == '0)
        else $error("length change did not clear accumulator");
    AST_G2R: assert property (
        col == COL_G2R && !wr_ctrl |=> disp_red_o == $past(any_on)
        && disp_green_o == !disp_red_o)
        else $error("green to red colour wrong");
    AST_FIX: assert property (
        col == COL_RED && !wr_ctrl |=> disp_red_o && !disp_green_o)
        else $error("fixed red colour wrong");
    AST_R2G: assert property (
        col == COL_R2G && !wr_ctrl |=> disp_green_o == $past(any_on)
        && disp_red_o == !disp_green_o)
        else $error("red to green colour wrong");
    AST_RAM: assert property (
        ram_fault_i |=> lvl_dark_o && err_code_o == ERR_RAM)
        else $error("working storage fault not shown");
    AST_NVM: assert property (
        nvm_fault_i && !ram_fault_i && !s_q.ram_err
        |=> !lvl_dark_o && err_code_o == ERR_NVM)
        else $error("nonvolatile fault not shown");
endmodule : alc_top

// [test/alc_fe_model.sv]
// Front-end model: hands scaled process values over as one-cycle updates
// Assumes the bench raises go_i for one cycle per wanted update
`timescale 1ns/1ns
module alc_fe_model (
    input  wire logic               clk_i,
    input  wire logic               go_i,
    input  wire logic signed [19:0] val_i,
    output logic signed [19:0]      pv_o,
    output logic                    pv_valid_o
);
    // Quiet start so the stage never sees unknowns
    initial begin
        pv_o = '0;
        pv_valid_o = 1'b0;
    end
    // Value valid only with the strobe; otherwise inverted junk
    always @(posedge clk_i) begin
        pv_valid_o <= go_i;
        pv_o       <= go_i ? val_i : ~pv_o;
    end
endmodule : alc_fe_model

// [test/tb.sv]
// Self-checking bench for the averaging limit comparator stage
// Assumes alc_pkg and the front-end model are compiled before it
`timescale 1ns/1ns
module tb;
    import alc_pkg::*;
    typedef struct {logic [1:0] act; int pv; logic c1; logic c2;} alc_row_t;
    logic               clk_i, resetn_i, psel, penable, pwrite, go, er;
    logic               pready_o, pslverr_o, pv_valid_i, ram_f, nvm_f, irq_o;
    logic               avg_vld_o, cmp1_o, cmp2_o, green, red, dark;
    logic [7:0]         paddr;
    logic [31:0]        pwdata, prdata_o, rd;
    logic [1:0]         err;
    logic signed [19:0] pv_i, val, avg_o;
    int                 bad_count = 0, checked = 0, vcnt = 0, sum, ex;
    int                 v[8] = '{-3, 7, 20, -11, 5, 9, -2, 6};
    alc_row_t rows[13] = '{'{ACT_UP, 100, 1, 1}, '{ACT_UP, 91, 1, 1}, '{ACT_UP, 90, 0, 1},
        '{ACT_UP, 99, 0, 1}, '{ACT_LO, -50, 1, 0}, '{ACT_LO, -41, 1, 0}, '{ACT_LO, -40, 0, 0},
        '{ACT_RNG, 100, 1, 1}, '{ACT_RNG, 91, 1, 1}, '{ACT_RNG, 90, 0, 1},
        '{ACT_RNG, -50, 1, 0}, '{ACT_RNG, -41, 1, 0}, '{ACT_RNG, -40, 0, 0}};

    // ------------------------------------------------
    // Clock, partner, design, pulse counter
    // ------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    alc_fe_model i_alc_fe_model (.clk_i(clk_i), .go_i(go), .val_i(val), .pv_o(pv_i),
        .pv_valid_o(pv_valid_i));
    alc_top #(.FAST_CYC(10), .SLOW_CYC(20)) i_alc_top (.clk_i(clk_i), .resetn_i(resetn_i),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .pv_i(pv_i), .pv_valid_i(pv_valid_i), .ram_fault_i(ram_f), .nvm_fault_i(nvm_f),
        .avg_o(avg_o), .avg_vld_o(avg_vld_o), .cmp1_o(cmp1_o), .cmp2_o(cmp2_o),
        .disp_green_o(green), .disp_red_o(red), .err_code_o(err), .lvl_dark_o(dark),
        .irq_o(irq_o));
    // Counts published averages
    always @(posedge clk_i) begin
        if (avg_vld_o === 1'b1) vcnt++;
    end

    // ------------------------------------------------
    // Tasks
    // ------------------------------------------------
    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : test_done
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One APB transfer; holds the request until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        @(posedge clk_i);
        while (pready_o !== 1'b1 && n < 50) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 50) bad_count++;
        if (n >= 50) test_done();
        r = prdata_o;
        e = pslverr_o;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // One update, then waits for the publish and one more cycle
    task automatic feed(input int x);
        int n;
        n = 0;
        @(posedge clk_i);
        go <= 1'b1;
        val <= 20'(x);
        @(posedge clk_i);
        go <= 1'b0;
        #1;
        while (avg_vld_o !== 1'b1 && n < 50) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        if (n >= 50) bad_count++;
        if (n >= 50) test_done();
        @(posedge clk_i);
        #1;
    endtask : feed

    // ------------------------------------------------
    // Main sequence
    // ------------------------------------------------
    initial begin
        {resetn_i, psel, penable, pwrite, go, ram_f, nvm_f} = '0;
        {paddr, pwdata, val} = '0;
        repeat (12) @(posedge clk_i);
        resetn_i <= 1'b1;
        apb(0, OFS_CTRL, 0, rd, er);
        chk(rd, 32'(CTRL_RST));
        chk({green, red}, 2'b10);
        apb(1, OFS_HYST, 10, rd, er);
        apb(1, OFS_SP1H, 100, rd, er);
        apb(1, OFS_SP1L, -50, rd, er);
        apb(1, OFS_SP2H, 95, rd, er);
        apb(0, OFS_SP1L, 0, rd, er);
        chk(rd, -50);
        // Table of actions and thresholds, out2 fixed upper
        foreach (rows[i]) begin
            apb(1, OFS_ACT, {28'h0, ACT_UP, rows[i].act}, rd, er);
            feed(rows[i].pv);
            chk(cmp1_o, rows[i].c1);
            chk(cmp2_o, rows[i].c2);
            chk(avg_o, rows[i].pv);
            @(posedge clk_i);
            #1;
            chk(green, !(rows[i].c1 | rows[i].c2));
        end
        // Every colour option with outputs off, then on
        for (int s = 0; s < 2; s++) begin
            if (s == 1) feed(200);
            for (int c = 0; c < 4; c++) begin
                apb(1, OFS_CTRL, 32'(c << 2), rd, er);
                repeat (3) @(posedge clk_i);
                #1;
                ex = (c == 0) ? !s : (c == 1) ? 1 : (c == 2) ? 0 : s;
                chk({green, red}, {ex[0], !ex[0]});
            end
        end
        // Back-to-back updates at every averaging length
        for (int s = 0; s < 4; s++) begin
            apb(1, OFS_CTRL, 32'(s), rd, er);
            vcnt = 0;
            sum = 0;
            for (int i = 0; i < 8; i++) begin
                @(posedge clk_i);
                go <= 1'b1;
                val <= 20'(v[i]);
            end
            @(posedge clk_i);
            go <= 1'b0;
            repeat (5) @(posedge clk_i);
            #1;
            for (int i = 8 - (1 << s); i < 8; i++) sum += v[i];
            chk(vcnt, 8 >> s);
            chk(avg_o, sum >>> s);
        end
        // Timer mode, N=2, both base intervals
        for (int k = 0; k < 2; k++) begin
            apb(1, OFS_CTRL, k ? 32'h31 : 32'h11, rd, er);
            vcnt = 0;
            repeat (200) @(posedge clk_i);
            #1;
            chk(vcnt inside {[9 - 5 * k : 11 - 5 * k]}, 1);
        end
        apb(1, OFS_CTRL, 0, rd, er);
        // Interrupt raise, mask, clear, and an unmapped access
        apb(1, OFS_IEN, 1, rd, er);
        apb(1, OFS_ICLR, 32'h1f, rd, er);
        feed(7);
        chk(irq_o, 1);
        apb(0, OFS_IST, 0, rd, er);
        chk(rd[0], 1);
        for (int k = 0; k < 3; k++) begin
            apb(1, k == 2 ? OFS_ICLR : OFS_IEN, k == 0 ? 0 : 1, rd, er);
            @(posedge clk_i);
            #1;
            chk(irq_o, k == 1);
        end
        apb(0, 8'h30, 0, rd, er);
        chk(er, 1);
        chk(rd, 0);
        // Nonvolatile fault first, then working storage fault wins
        for (int k = 0; k < 2; k++) begin
            @(posedge clk_i);
            {ram_f, nvm_f} <= k ? 2'b10 : 2'b01;
            @(posedge clk_i);
            {ram_f, nvm_f} <= 2'b00;
            @(posedge clk_i);
            #1;
            chk({err, dark}, k ? {ERR_RAM, 1'b1} : {ERR_NVM, 1'b0});
        end
        // Reset in mid-run
        @(posedge clk_i);
        resetn_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        resetn_i <= 1'b1;
        apb(0, OFS_IEN, 0, rd, er);
        chk(rd, 0);
        chk({err, dark, cmp1_o, irq_o, green}, {ERR_NONE, 4'b0001});
        test_done();
    end
endmodule : tb
